// *** shared/vrseq_pkg.sv ***
// ==========================================================
// Voltage rail sequencer shared definitions
package vrseq_pkg;

    // ======================================================
    // Sizes
    localparam int MAX_RAILS = 16;
    localparam int VOLT_W = 16;
    localparam int DLY_W = 8;
    localparam int SLOT_W = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ======================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_POLARITY = 8'h04;
    localparam logic [7:0] ADDR_RAMP = 8'h08;
    localparam logic [7:0] ADDR_UPDLY = 8'h0C;
    localparam logic [7:0] ADDR_DNDLY = 8'h10;
    localparam logic [7:0] ADDR_SLOT_LO = 8'h14;
    localparam logic [7:0] ADDR_SLOT_HI = 8'h18;
    localparam logic [7:0] ADDR_STATE = 8'h1C;
    localparam logic [7:0] ADDR_UV = 8'h20;
    localparam logic [7:0] ADDR_OV = 8'h24;
    localparam logic [7:0] ADDR_INT_STAT = 8'h28;
    localparam logic [7:0] ADDR_INT_MASK = 8'h2C;
    localparam logic [1:0] AREA_UV_THR = 2'h1;
    localparam logic [1:0] AREA_OV_THR = 2'h2;

    // ======================================================
    // Fields and reset values
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_SHUT_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam logic [15:0] POLARITY_RESET = 16'hFFFF;
    localparam logic [7:0] RAMP_RESET = 8'h0A;
    localparam logic [7:0] UPDLY_RESET = 8'h0A;
    localparam logic [7:0] DNDLY_RESET = 8'h0A;
    localparam logic [63:0] SLOT_MAP_RESET = 64'hFEDCBA9876543210;
    localparam logic [15:0] INT_MASK_RESET = 16'h0000;
    localparam int STATE_SLOT_LSB = 8;
    localparam int STATE_ON_LSB = 16;

    // Default window is nominal minus and plus 7.5 percent
    localparam int WIN_LO_PERMILLE = 925;
    localparam int WIN_HI_PERMILLE = 1075;

    // ======================================================
    // Timing: one sequencer tick is one millisecond
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_UNIT_US = 1000;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_UNIT_US;

    // ======================================================
    // Types
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_RAMP = 6'h02,
        ST_UPDLY = 6'h04,
        ST_ON = 6'h08,
        ST_DOWN = 6'h10,
        ST_FAULT = 6'h20
    } vrseq_state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } vrseq_bus_req_type;

    typedef struct packed {
        logic good;
        logic under;
        logic over;
    } vrseq_rail_stat_type;

endpackage

// *** hdl/vrseq_window.sv ***
`timescale 1ns/100ps
// ==========================================================
// Per-rail power-good qualifier with voltage window check
module vrseq_window (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic power_good_in, // Regulator power-good pin
    input wire logic [vrseq_pkg::VOLT_W-1:0] voltage_in, // Measured rail voltage, same clock
    input wire logic [vrseq_pkg::VOLT_W-1:0] uv_thr, // Under-voltage threshold
    input wire logic [vrseq_pkg::VOLT_W-1:0] ov_thr, // Over-voltage threshold
    output vrseq_pkg::vrseq_rail_stat_type stat // Qualified rail status
);
    logic pg_s1_r;
    logic pg_s2_r;
    logic pg_s3_r;
    logic pg_r;
    logic under_r;
    logic over_r;

    // ======================================================
    // Pin synchroniser; a change counts once stages 2 and 3 agree
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pg_s1_r <= 1'b0;
            pg_s2_r <= 1'b0;
            pg_s3_r <= 1'b0;
            pg_r <= 1'b0;
        end else begin
            pg_s1_r <= power_good_in;
            pg_s2_r <= pg_s1_r;
            pg_s3_r <= pg_s2_r;
            if (pg_s2_r == pg_s3_r) begin
                pg_r <= pg_s3_r;
            end
        end
    end

    // ======================================================
    // Window comparator
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            under_r <= 1'b0;
            over_r <= 1'b0;
        end else begin
            under_r <= voltage_in < uv_thr;
            over_r <= voltage_in > ov_thr;
        end
    end

    // Power-good is the pin qualified by the window
    assign stat.good = pg_r & ~under_r & ~over_r;
    assign stat.under = under_r;
    assign stat.over = over_r;

endmodule

// *** hdl/vrseq_top.sv ***
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
// ==========================================================
// Behaviour
// - Sequence power-up and power-down order and timing for up to sixteen rails.
// - Each rail has a digital power-good input used as pass or fail.
// - Power-good also needs the rail inside per-rail programmable UV and OV thresholds.
// - Default window is nominal plus or minus 7.5 percent.
// - Rails map to ordered slots; default one rail per slot, up in order.
// - After enabling a slot, wait the ramp time before judging power-good.
// - After a slot passes, wait the up-delay before starting the next slot.
// - Ramp and delays count one millisecond ticks; unit is a parameter.
// - Each enable output has a programmable polarity, active high selectable.
// - If configured, any rail fault during power-up or while on drops every enable at once.
// - Automatic power-up and power-down; rail faults raise an interrupt.
// - Each rail reports in range, under-voltage or over-voltage.
// - After a fault shutdown, held retry input restarts the power-up.
module vrseq_top #(
    parameter int NRAILS = 4,
    parameter int NSLOTS = NRAILS,
    parameter int TICK_CYCLES = vrseq_pkg::TICK_CYCLES,
    parameter logic [vrseq_pkg::MAX_RAILS*vrseq_pkg::VOLT_W-1:0] RAIL_NOM_MV =
        {192'h0, 16'h0708, 16'h09C4, 16'h0CE4, 16'h1388}
) (
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input vrseq_pkg::vrseq_bus_req_type bus_req, // Register request
    output logic [vrseq_pkg::DATA_W-1:0] bus_rdata, // Read data, cycle after read
    input wire logic [NRAILS-1:0] power_good_in, // Regulator power-good pins
    input wire logic [NRAILS*vrseq_pkg::VOLT_W-1:0] rail_voltage_in, // Measured voltages in mV
    input wire logic retry_in, // Retry push-button, active high
    output logic [NRAILS-1:0] rail_enable_out, // Regulator enables
    output logic irq_out // Rail-fail interrupt, level
);
    localparam int M = vrseq_pkg::MAX_RAILS;
    localparam logic [15:0] RAIL_VALID = 16'((32'h1 << NRAILS) - 32'h1);
    localparam logic [3:0] LAST_SLOT = 4'(NSLOTS - 1);
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    // ======================================================
    // Helpers
    function automatic logic [15:0] slot_mask(input logic [63:0] map, input logic [3:0] s);
        logic [15:0] m;
        m = 16'h0000;
        for (int i = 0; i < M; i++) begin
            m[i] = map[i*4 +: 4] == s;
        end
        return m & RAIL_VALID;
    endfunction

    function automatic logic [15:0] thr_default(input logic [15:0] nom, input int permille);
        return 16'((32'(nom) * permille) / 1000);
    endfunction

    // ======================================================
    // Storage
    logic [1:0] ctrl_r;
    logic [15:0] polarity_r;
    logic [7:0] ramp_r;
    logic [7:0] updly_r;
    logic [7:0] dndly_r;
    logic [63:0] slot_map_r;
    logic [15:0] uv_thr_r [M];
    logic [15:0] ov_thr_r [M];
    logic [15:0] int_stat_r;
    logic [15:0] int_mask_r;
    logic [15:0] int_stat_nxt;
    vrseq_pkg::vrseq_state_type state_r;
    logic [3:0] cur_r;
    logic [15:0] on_r;
    logic [15:0] armed_r;
    logic [15:0] fail_prev_r;
    logic [7:0] cnt_r;
    logic [TICK_W-1:0] tick_cnt_r;
    logic tick_r;
    logic retry_s1_r;
    logic retry_s2_r;
    logic retry_s3_r;
    logic retry_r;
    logic [15:0] good_vec;
    logic [15:0] under_vec;
    logic [15:0] over_vec;
    logic [15:0] fail_now;
    logic [15:0] ramp_fail;
    logic [15:0] cur_mask;
    logic ramp_done;
    logic run;
    logic shut_en;
    logic wr_hit;

    assign run = ctrl_r[vrseq_pkg::CTRL_RUN_BIT];
    assign shut_en = ctrl_r[vrseq_pkg::CTRL_SHUT_BIT];
    assign wr_hit = bus_req.wr;

    // ======================================================
    // Rail monitors
    for (genvar g = 0; g < M; g++) begin : g_rail
        if (g < NRAILS) begin : g_used
            vrseq_pkg::vrseq_rail_stat_type st;
            vrseq_window u_win (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .power_good_in(power_good_in[g]),
                .voltage_in(rail_voltage_in[g*vrseq_pkg::VOLT_W +: vrseq_pkg::VOLT_W]),
                .uv_thr(uv_thr_r[g]),
                .ov_thr(ov_thr_r[g]),
                .stat(st)
            );
            assign good_vec[g] = st.good;
            assign under_vec[g] = st.under;
            assign over_vec[g] = st.over;
        end else begin : g_none
            assign good_vec[g] = 1'b0;
            assign under_vec[g] = 1'b0;
            assign over_vec[g] = 1'b0;
        end
    end

    // ======================================================
    // Millisecond tick and retry input
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (tick_cnt_r == TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            retry_s1_r <= 1'b0;
            retry_s2_r <= 1'b0;
            retry_s3_r <= 1'b0;
            retry_r <= 1'b0;
        end else begin
            retry_s1_r <= retry_in;
            retry_s2_r <= retry_s1_r;
            retry_s3_r <= retry_s2_r;
            if (retry_s2_r == retry_s3_r) begin
                retry_r <= retry_s3_r;
            end
        end
    end

    // ======================================================
    // Sequencer
    assign cur_mask = slot_mask(slot_map_r, cur_r);
    assign ramp_done = cnt_r == ramp_r;
    assign ramp_fail = (state_r == vrseq_pkg::ST_RAMP && ramp_done) ? (cur_mask & ~good_vec) : 16'h0000;
    assign fail_now = armed_r & ~good_vec;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_r <= vrseq_pkg::ST_OFF;
            cur_r <= 4'h0;
            on_r <= 16'h0000;
            armed_r <= 16'h0000;
            cnt_r <= 8'h00;
        end else begin
            unique case (state_r)
                vrseq_pkg::ST_OFF: begin
                    if (run) begin
                        state_r <= vrseq_pkg::ST_RAMP;
                        cur_r <= 4'h0;
                        on_r <= slot_mask(slot_map_r, 4'h0);
                        cnt_r <= 8'h00;
                    end
                end
                vrseq_pkg::ST_RAMP, vrseq_pkg::ST_UPDLY, vrseq_pkg::ST_ON: begin
                    if (shut_en && ((|fail_now) || (|ramp_fail))) begin
                        state_r <= vrseq_pkg::ST_FAULT;
                        on_r <= 16'h0000;
                        armed_r <= 16'h0000;
                    end else if (!run) begin
                        state_r <= vrseq_pkg::ST_DOWN;
                        on_r <= on_r & ~cur_mask;
                        armed_r <= armed_r & ~cur_mask;
                        cnt_r <= 8'h00;
                    end else if (state_r == vrseq_pkg::ST_RAMP) begin
                        if (ramp_done) begin
                            state_r <= vrseq_pkg::ST_UPDLY;
                            armed_r <= armed_r | cur_mask;
                            cnt_r <= 8'h00;
                        end else if (tick_r) begin
                            cnt_r <= cnt_r + 8'h01;
                        end
                    end else if (state_r == vrseq_pkg::ST_UPDLY) begin
                        if (cnt_r == updly_r) begin
                            cnt_r <= 8'h00;
                            if (cur_r == LAST_SLOT) begin
                                state_r <= vrseq_pkg::ST_ON;
                            end else begin
                                state_r <= vrseq_pkg::ST_RAMP;
                                cur_r <= cur_r + 4'h1;
                                on_r <= on_r | slot_mask(slot_map_r, cur_r + 4'h1);
                            end
                        end else if (tick_r) begin
                            cnt_r <= cnt_r + 8'h01;
                        end
                    end
                end
                vrseq_pkg::ST_DOWN: begin
                    if (cnt_r == dndly_r) begin
                        cnt_r <= 8'h00;
                        if (cur_r == 4'h0) begin
                            state_r <= vrseq_pkg::ST_OFF;
                        end else begin
                            cur_r <= cur_r - 4'h1;
                            on_r <= on_r & ~slot_mask(slot_map_r, cur_r - 4'h1);
                            armed_r <= armed_r & ~slot_mask(slot_map_r, cur_r - 4'h1);
                        end
                    end else if (tick_r) begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
                vrseq_pkg::ST_FAULT: begin
                    // Retry must still be high on a tick, so a glitch does not restart
                    if (!run) begin
                        state_r <= vrseq_pkg::ST_OFF;
                    end else if (retry_r && tick_r) begin
                        state_r <= vrseq_pkg::ST_RAMP;
                        cur_r <= 4'h0;
                        on_r <= slot_mask(slot_map_r, 4'h0);
                        cnt_r <= 8'h00;
                    end
                end
                default: begin
                    state_r <= vrseq_pkg::ST_OFF;
                    on_r <= 16'h0000;
                    armed_r <= 16'h0000;
                end
            endcase
        end
    end

    // Enable pins follow the rail state through the programmed polarity
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rail_enable_out <= ~vrseq_pkg::POLARITY_RESET[NRAILS-1:0];
        end else begin
            rail_enable_out <= ~(on_r[NRAILS-1:0] ^ polarity_r[NRAILS-1:0]);
        end
    end

    // ======================================================
    // Rail-fail events and interrupt
    always_comb begin
        int_stat_nxt = int_stat_r;
        if (wr_hit && bus_req.addr == vrseq_pkg::ADDR_INT_STAT) begin
            int_stat_nxt = int_stat_nxt & ~bus_req.wdata[15:0];
        end
        // Set after clear so an event in the clearing cycle is kept
        int_stat_nxt = int_stat_nxt | ((fail_now & ~fail_prev_r) | ramp_fail);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            int_stat_r <= 16'h0000;
            fail_prev_r <= 16'h0000;
            irq_out <= 1'b0;
        end else begin
            int_stat_r <= int_stat_nxt;
            fail_prev_r <= fail_now;
            irq_out <= |(int_stat_r & int_mask_r);
        end
    end

    // ======================================================
    // Register writes
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= vrseq_pkg::CTRL_RESET;
            polarity_r <= vrseq_pkg::POLARITY_RESET;
            ramp_r <= vrseq_pkg::RAMP_RESET;
            updly_r <= vrseq_pkg::UPDLY_RESET;
            dndly_r <= vrseq_pkg::DNDLY_RESET;
            slot_map_r <= vrseq_pkg::SLOT_MAP_RESET;
            int_mask_r <= vrseq_pkg::INT_MASK_RESET;
            for (int i = 0; i < M; i++) begin
                uv_thr_r[i] <= thr_default(RAIL_NOM_MV[i*16 +: 16], vrseq_pkg::WIN_LO_PERMILLE);
                ov_thr_r[i] <= thr_default(RAIL_NOM_MV[i*16 +: 16], vrseq_pkg::WIN_HI_PERMILLE);
            end
        end else if (wr_hit) begin
            unique case (bus_req.addr)
                vrseq_pkg::ADDR_CTRL: ctrl_r <= bus_req.wdata[1:0];
                vrseq_pkg::ADDR_POLARITY: polarity_r <= bus_req.wdata[15:0];
                vrseq_pkg::ADDR_RAMP: ramp_r <= bus_req.wdata[7:0];
                vrseq_pkg::ADDR_UPDLY: updly_r <= bus_req.wdata[7:0];
                vrseq_pkg::ADDR_DNDLY: dndly_r <= bus_req.wdata[7:0];
                vrseq_pkg::ADDR_SLOT_LO: slot_map_r[31:0] <= bus_req.wdata;
                vrseq_pkg::ADDR_SLOT_HI: slot_map_r[63:32] <= bus_req.wdata;
                vrseq_pkg::ADDR_INT_MASK: int_mask_r <= bus_req.wdata[15:0];
                default: begin
                    if (bus_req.addr[7:6] == vrseq_pkg::AREA_UV_THR) begin
                        uv_thr_r[bus_req.addr[5:2]] <= bus_req.wdata[15:0];
                    end
                    if (bus_req.addr[7:6] == vrseq_pkg::AREA_OV_THR) begin
                        ov_thr_r[bus_req.addr[5:2]] <= bus_req.wdata[15:0];
                    end
                end
            endcase
        end
    end

    // ======================================================
    // Register reads, data in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bus_rdata <= 32'h00000000;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                vrseq_pkg::ADDR_CTRL: bus_rdata <= {30'h0, ctrl_r};
                vrseq_pkg::ADDR_POLARITY: bus_rdata <= {16'h0, polarity_r};
                vrseq_pkg::ADDR_RAMP: bus_rdata <= {24'h0, ramp_r};
                vrseq_pkg::ADDR_UPDLY: bus_rdata <= {24'h0, updly_r};
                vrseq_pkg::ADDR_DNDLY: bus_rdata <= {24'h0, dndly_r};
                vrseq_pkg::ADDR_SLOT_LO: bus_rdata <= slot_map_r[31:0];
                vrseq_pkg::ADDR_SLOT_HI: bus_rdata <= slot_map_r[63:32];
                vrseq_pkg::ADDR_STATE: bus_rdata <= {on_r, 4'h0, cur_r, 2'h0, state_r};
                vrseq_pkg::ADDR_UV: bus_rdata <= {16'h0, under_vec};
                vrseq_pkg::ADDR_OV: bus_rdata <= {16'h0, over_vec};
                vrseq_pkg::ADDR_INT_STAT: bus_rdata <= {16'h0, int_stat_r};
                vrseq_pkg::ADDR_INT_MASK: bus_rdata <= {16'h0, int_mask_r};
                default: begin
                    if (bus_req.addr[7:6] == vrseq_pkg::AREA_UV_THR) begin
                        bus_rdata <= {16'h0, uv_thr_r[bus_req.addr[5:2]]};
                    end else if (bus_req.addr[7:6] == vrseq_pkg::AREA_OV_THR) begin
                        bus_rdata <= {16'h0, ov_thr_r[bus_req.addr[5:2]]};
                    end else begin
                        bus_rdata <= 32'h00000000;
                    end
                end
            endcase
        end else begin
            bus_rdata <= 32'h00000000;
        end
    end

endmodule

// *** testbench/vrseq_checker.sv ***
`timescale 1ns/100ps
// ==========================================================
// Port-level checks of the rail sequencer
module vrseq_checker #(
    parameter int NRAILS = 4,
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Reset, active low
    input wire vrseq_pkg::vrseq_bus_req_type bus_req, // Register request
    input wire logic [vrseq_pkg::DATA_W-1:0] bus_rdata, // Read data
    input wire logic [NRAILS-1:0] power_good_in, // Power-good pins
    input wire logic [NRAILS*vrseq_pkg::VOLT_W-1:0] rail_voltage_in, // Rail voltages
    input wire logic retry_in, // Retry button
    input wire logic [NRAILS-1:0] rail_enable_out, // Regulator enables
    input wire logic irq_out // Interrupt
);
    // Each count may run one tick phase short or long
    localparam int GAP_MIN = (vrseq_pkg::RAMP_RESET + vrseq_pkg::UPDLY_RESET - 2) * TICK_CYCLES;
    localparam int GAP_MAX = (vrseq_pkg::RAMP_RESET + vrseq_pkg::UPDLY_RESET + 2) * TICK_CYCLES + 10;
    int gap_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gap_r <= 0;
        end else if ($rose(rail_enable_out[0])) begin
            gap_r <= 1;
        end else if (gap_r < 100000) begin
            gap_r <= gap_r + 1;
        end
    end
    sequence s_first_slot;
        rail_enable_out == '0 ##[1:3] rail_enable_out[0];
    endsequence
    sequence s_irq_low;
        ##2 !irq_out;
    endsequence
    a_auto_power_up: assert property ($rose(rstn) |-> s_first_slot)
        else $error("slot zero not enabled after reset");
    a_slot_order_up: assert property ($rose(rail_enable_out[1]) |-> rail_enable_out[0])
        else $error("rail one enabled before rail zero");
    a_slot_gap_time: assert property ($rose(rail_enable_out[1]) && !$rose(rail_enable_out[0])
        |-> gap_r >= GAP_MIN && gap_r <= GAP_MAX) else $error("slot gap outside ramp plus up-delay");
    a_fault_drops_all: assert property ($fell(power_good_in[2]) && rail_enable_out == '1
        |-> ##[1:12] rail_enable_out == '0) else $error("enables kept after fault");
    a_stat_clear_irq: assert property (bus_req.wr && bus_req.addr == 8'h28 && bus_req.wdata[3:0] == 4'hF
        && rail_enable_out == '0 |-> s_irq_low) else $error("irq kept after status clear");
    a_mask_off_irq: assert property (bus_req.wr && bus_req.addr == 8'h2C && bus_req.wdata[15:0] == 16'h0
        |-> s_irq_low) else $error("irq kept with mask cleared");
    a_down_reverse: assert property ($fell(rail_enable_out[0]) && !$fell(rail_enable_out[3])
        |-> !rail_enable_out[1]) else $error("rail zero off before rail one");
    a_down_middle: assert property ($fell(rail_enable_out[1]) && !$fell(rail_enable_out[3])
        |-> !rail_enable_out[2]) else $error("rail one off before rail two");
endmodule
bind vrseq_top vrseq_checker #(.NRAILS(NRAILS), .TICK_CYCLES(TICK_CYCLES)) u_checker (.clk_sys(clk_sys),
    .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata), .power_good_in(power_good_in),
    .rail_voltage_in(rail_voltage_in), .retry_in(retry_in), .rail_enable_out(rail_enable_out), .irq_out(irq_out));

// *** testbench/vrseq_regulator_model.sv ***
`timescale 1ns/100ps
// ==========================================================
// Four regulators: output settles some cycles after enable
module vrseq_regulator_model #(
    parameter int NRAILS = 4,
    parameter int RISE_CYCLES = 6,
    parameter logic [63:0] NOM_MV = {16'h0708, 16'h09C4, 16'h0CE4, 16'h1388}
) (
    input wire logic clk_sys, // System clock
    input wire logic [NRAILS-1:0] enable_in, // Enables, active high
    input wire logic [NRAILS-1:0] drop_in, // Collapse output, power-good low
    input wire logic [NRAILS-1:0] surge_in, // Over-voltage, power-good kept
    output logic [NRAILS-1:0] power_good_out, // Power-good pins
    output logic [NRAILS*16-1:0] voltage_out // Output voltages in mV
);
    int rise_cnt [NRAILS];
    initial power_good_out = '0;
    initial voltage_out = '0;
    always @(posedge clk_sys) begin
        for (int i = 0; i < NRAILS; i++) begin
            rise_cnt[i] <= (!enable_in[i] || drop_in[i]) ? 0 : rise_cnt[i] + int'(rise_cnt[i] < RISE_CYCLES);
            power_good_out[i] <= enable_in[i] && !drop_in[i] && rise_cnt[i] == RISE_CYCLES;
            // A surge leaves the pin good so only the window can catch it
            voltage_out[16*i +: 16] <= !enable_in[i] ? 16'h0 : surge_in[i] ? 16'(NOM_MV[16*i +: 16] * 9 / 8)
                : (drop_in[i] || rise_cnt[i] < RISE_CYCLES) ? NOM_MV[16*i +: 16] >> 1 : NOM_MV[16*i +: 16];
        end
    end
endmodule

// *** testbench/test_vrseq_top.sv ***
`timescale 1ns/100ps
module test_vrseq_top;
    localparam int TICKS = 4;
    logic clk_sys = 1'b0, rstn = 1'b0;
    vrseq_pkg::vrseq_bus_req_type bus_req = '0;
    logic [31:0] bus_rdata;
    logic [3:0] power_good_in;
    logic [63:0] rail_voltage_in;
    logic retry_in = 1'b0;
    logic [3:0] rail_enable_out;
    logic irq_out;
    logic [3:0] drop = '0, surge = '0;
    int num_errors = 0, n_tests = 0;
    always #25 clk_sys = ~clk_sys;
    vrseq_top #(.NRAILS(4), .TICK_CYCLES(TICKS)) DUT (.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .power_good_in(power_good_in), .rail_voltage_in(rail_voltage_in),
        .retry_in(retry_in), .rail_enable_out(rail_enable_out), .irq_out(irq_out));
    vrseq_regulator_model #(.NRAILS(4)) u_regs (.clk_sys(clk_sys), .enable_in(rail_enable_out), .drop_in(drop),
        .surge_in(surge), .power_good_out(power_good_in), .voltage_out(rail_voltage_in));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk_sys);
        bus_req <= '0;
        #1;
        chk(what, exp, bus_rdata);
    endtask
    task automatic wait_en(input logic [3:0] v, input int lim);
        int n = 0;
        while (rail_enable_out !== v && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("rail_enable_out", {28'h0, v}, {28'h0, rail_enable_out});
    endtask
    task automatic stop_test();
        $display("Checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        bus_rd(vrseq_pkg::ADDR_CTRL, {30'h0, vrseq_pkg::CTRL_RESET}, "ctrl");
        bus_rd(vrseq_pkg::ADDR_POLARITY, {16'h0, vrseq_pkg::POLARITY_RESET}, "polarity");
        bus_rd(vrseq_pkg::ADDR_RAMP, {24'h0, vrseq_pkg::RAMP_RESET}, "ramp");
        bus_rd(vrseq_pkg::ADDR_SLOT_LO, vrseq_pkg::SLOT_MAP_RESET[31:0], "slot map");
        bus_rd(8'h40, 32'(5000 * vrseq_pkg::WIN_LO_PERMILLE / 1000), "uv threshold");
        bus_rd(8'h80, 32'(5000 * vrseq_pkg::WIN_HI_PERMILLE / 1000), "ov threshold");
        bus_rd(8'h30, 32'h0, "unmapped");
        bus_wr(vrseq_pkg::ADDR_INT_MASK, 32'hF);
        wait_en(4'hF, 1000);
        // Events only, no shutdown: a window failure must not drop any rail
        bus_wr(vrseq_pkg::ADDR_CTRL, 32'h1);
        surge <= 4'h2;
        repeat (8) @(posedge clk_sys);
        bus_rd(vrseq_pkg::ADDR_UV, 32'h0, "under flags");
        bus_rd(vrseq_pkg::ADDR_OV, 32'h2, "over flags");
        bus_rd(vrseq_pkg::ADDR_INT_STAT, 32'h2, "surge event");
        chk("enables kept", 32'hF, {28'h0, rail_enable_out});
        chk("irq on event", 32'h1, {31'h0, irq_out});
        bus_wr(vrseq_pkg::ADDR_INT_MASK, 32'h0);
        bus_wr(vrseq_pkg::ADDR_INT_MASK, 32'hF);
        surge <= 4'h0;
        bus_wr(vrseq_pkg::ADDR_INT_STAT, 32'h2);
        bus_rd(vrseq_pkg::ADDR_INT_STAT, 32'h0, "status cleared");
        bus_wr(vrseq_pkg::ADDR_CTRL, 32'h3);
        drop <= 4'h4;
        wait_en(4'h0, 20);
        repeat (2) @(negedge clk_sys);
        chk("irq on fault", 32'h1, {31'h0, irq_out});
        bus_rd(vrseq_pkg::ADDR_UV, 32'hF, "under flags off");
        bus_wr(vrseq_pkg::ADDR_INT_STAT, 32'hF);
        drop <= 4'h0;
        repeat (40) @(negedge clk_sys);
        chk("no restart", 32'h0, {28'h0, rail_enable_out});
        chk("irq cleared", 32'h0, {31'h0, irq_out});
        @(posedge clk_sys);
        retry_in <= 1'b1;
        wait_en(4'h1, 3 * TICKS + 20);
        @(posedge clk_sys);
        retry_in <= 1'b0;
        wait_en(4'hF, 1000);
        bus_wr(vrseq_pkg::ADDR_CTRL, 32'h2);
        wait_en(4'h7, 20);
        wait_en(4'h3, 100);
        wait_en(4'h0, 200);
        bus_wr(vrseq_pkg::ADDR_POLARITY, 32'h0);
        wait_en(4'hF, 4);
        bus_wr(vrseq_pkg::ADDR_POLARITY, 32'hFFFF);
        wait_en(4'h0, 4);
        bus_wr(8'h84, 32'h00000FA0);
        bus_rd(8'h84, 32'h00000FA0, "ov threshold written");
        stop_test();
    end
endmodule
